// File: hw/timer2_pkg.sv
`default_nettype none
package timer2_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte addresses
    localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'hC8;
    localparam logic [ADDR_W-1:0] ADDR_COUNT = 8'hCC;
    localparam logic [ADDR_W-1:0] ADDR_RELOAD = 8'hD0;
    localparam logic [ADDR_W-1:0] ADDR_CLOCK_CONTROL = 8'hD4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'hD8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLEAR = 8'hDC;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_ENABLE = 8'hE0;

    // Reset values and the all-ones rollover byte
    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] BYTE_RESET = 8'h00;
    localparam logic [2:0] IRQ_RESET = 3'h0;
    localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;

    // Interrupt status and enable bit positions
    localparam int IRQ_HIGH = 0;
    localparam int IRQ_LOW = 1;
    localparam int IRQ_CAPTURE = 2;

    // Clock control bit positions
    localparam int CLKSEL_LOW = 0;
    localparam int CLKSEL_HIGH = 1;

    // Prescaler counts
    localparam logic [3:0] SYS_DIV_LAST = 4'hB;
    localparam logic [2:0] EXT_DIV_LAST = 3'h7;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic high_byte_overflow_flag;
        logic low_byte_overflow_flag;
        logic low_byte_irq_enable;
        logic lfo_capture_enable;
        logic split_mode_enable;
        logic run_control;
        logic unused;
        logic external_clock_select;
    } ctrl_s;

    typedef struct packed {
        logic div12;
        logic ext8;
        logic lfo_fall;
    } tick_s;

    typedef enum {
        SEL_CONTROL,
        SEL_COUNT,
        SEL_RELOAD,
        SEL_CLOCK_CONTROL,
        SEL_IRQ_STATUS,
        SEL_IRQ_CLEAR,
        SEL_IRQ_ENABLE,
        SEL_NONE
    } reg_sel_e;

    function automatic reg_sel_e decode_reg(input logic [ADDR_W-1:0] addr);
        unique case (addr)
            ADDR_CONTROL: decode_reg = SEL_CONTROL;
            ADDR_COUNT: decode_reg = SEL_COUNT;
            ADDR_RELOAD: decode_reg = SEL_RELOAD;
            ADDR_CLOCK_CONTROL: decode_reg = SEL_CLOCK_CONTROL;
            ADDR_IRQ_STATUS: decode_reg = SEL_IRQ_STATUS;
            ADDR_IRQ_CLEAR: decode_reg = SEL_IRQ_CLEAR;
            ADDR_IRQ_ENABLE: decode_reg = SEL_IRQ_ENABLE;
            default: decode_reg = SEL_NONE;
        endcase
    endfunction : decode_reg

endpackage : timer2_pkg
`default_nettype wire

// File: hw/clock_tick_source.sv
`default_nettype none
module clock_tick_source (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ext_clk_in,
    input wire logic lfo_in,
    output timer2_pkg::tick_s ticks
);
    import timer2_pkg::*;

    logic ext_meta;
    logic ext_sync;
    logic ext_prev;
    logic lfo_meta;
    logic lfo_sync;
    logic lfo_prev;
    logic [3:0] sys_div;
    logic [2:0] ext_div;
    logic div12_q;
    logic ext8_q;
    logic lfo_fall_q;

    assign ticks = '{div12: div12_q, ext8: ext8_q, lfo_fall: lfo_fall_q};

    // Two-stage synchronisers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_meta <= 1'h0;
            ext_sync <= 1'h0;
            ext_prev <= 1'h0;
            lfo_meta <= 1'h0;
            lfo_sync <= 1'h0;
            lfo_prev <= 1'h0;
        end else begin
            ext_meta <= ext_clk_in;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
            lfo_meta <= lfo_in;
            lfo_sync <= lfo_meta;
            lfo_prev <= lfo_sync;
        end
    end

    // System clock divided by 12
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sys_div <= 4'h0;
            div12_q <= 1'h0;
        end else begin
            div12_q <= (sys_div == SYS_DIV_LAST);
            sys_div <= (sys_div == SYS_DIV_LAST) ? 4'h0 : sys_div + 4'h1;
        end
    end

    // External clock rising edges divided by 8
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ext_div <= 3'h0;
            ext8_q <= 1'h0;
        end else begin
            ext8_q <= ext_sync && !ext_prev && (ext_div == EXT_DIV_LAST);
            if (ext_sync && !ext_prev) begin
                ext_div <= ext_div + 3'h1;
            end
        end
    end

    // Oscillator falling edge
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lfo_fall_q <= 1'h0;
        end else begin
            lfo_fall_q <= !lfo_sync && lfo_prev;
        end
    end

endmodule : clock_tick_source
`default_nettype wire

// File: hw/split_mode_auto_reload_timer.sv
// Summary of operation
// - Split mode runs two 8-bit auto-reload counters.
// - Split cleared runs one 16-bit reloading counter.
// - Each byte reloads from its own reload byte.
// - Split mode: run gates high byte only.
// - Run bit starts and stops the counter.
// - Per-byte select: system clock or shared source.
// - One external select serves both bytes.
// - External clock synchronised, divided by eight.
// - High flag set on high byte rollover.
// - In 16-bit mode, full rollover sets high flag.
// - Low flag set on any low rollover.
// - Timer enable: high flag raises interrupt.
// - Low enable adds low overflow to interrupt.
// - Flags stay set until software clears them.
// - Capture count into reload on oscillator fall.
// - Control bit one reads zero, ignores writes.
// - Control at 0xC8, bit access, resets zero.
//
// Chosen here: register access over AXI4-Lite.
`default_nettype none
module split_mode_auto_reload_timer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [timer2_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [timer2_pkg::DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [timer2_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [timer2_pkg::DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ext_clk_in,
    input wire logic lfo_in,
    output logic irq
);
    import timer2_pkg::*;

    ctrl_s ctrl;
    tick_s ticks;
    logic [7:0] count_high_byte;
    logic [7:0] count_low_byte;
    logic [7:0] reload_high_byte;
    logic [7:0] reload_low_byte;
    logic [1:0] clock_control;
    logic capture_flag;
    logic [2:0] irq_enable;
    logic [2:0] irq_status;
    logic [ADDR_W-1:0] aw_addr;
    logic [DATA_W-1:0] w_data;
    logic [3:0] w_strb;
    logic have_aw;
    logic have_w;
    logic do_write;
    reg_sel_e wr_sel;
    reg_sel_e rd_sel;
    logic [DATA_W-1:0] rd_word;
    logic wr_ctrl;
    logic wr_cnt_lo;
    logic wr_cnt_hi;
    logic wr_rl_lo;
    logic wr_rl_hi;
    logic wr_clr;
    logic lo_tick;
    logic hi_tick;
    logic lo_ovf;
    logic hi_ovf;
    logic capture;
    logic [7:0] next_lo;
    logic [7:0] next_hi;
    function automatic logic pick_tick(input logic sys_sel, input logic ext_sel, input tick_s t);
        pick_tick = sys_sel ? 1'h1 : (ext_sel ? t.ext8 : t.div12);
    endfunction : pick_tick

    clock_tick_source u_ticks (
        .aclk(aclk),
        .aresetn(aresetn),
        .ext_clk_in(ext_clk_in),
        .lfo_in(lfo_in),
        .ticks(ticks)
    );
    // Write channel capture and response
    assign do_write = have_aw && have_w && !s_axi_bvalid;
    assign wr_sel = decode_reg(aw_addr);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'h1;
            s_axi_wready <= 1'h1;
            s_axi_bvalid <= 1'h0;
            s_axi_bresp <= RESP_OKAY;
            have_aw <= 1'h0;
            have_w <= 1'h0;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr <= s_axi_awaddr;
                have_aw <= 1'h1;
                s_axi_awready <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
                have_w <= 1'h1;
                s_axi_wready <= 1'h0;
            end
            if (do_write) begin
                have_aw <= 1'h0;
                have_w <= 1'h0;
                s_axi_bvalid <= 1'h1;
                s_axi_bresp <= (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'h0;
                s_axi_awready <= 1'h1;
                s_axi_wready <= 1'h1;
            end
        end
    end

    assign wr_ctrl = do_write && (wr_sel == SEL_CONTROL) && w_strb[0];
    assign wr_cnt_lo = do_write && (wr_sel == SEL_COUNT) && w_strb[0];
    assign wr_cnt_hi = do_write && (wr_sel == SEL_COUNT) && w_strb[1];
    assign wr_rl_lo = do_write && (wr_sel == SEL_RELOAD) && w_strb[0];
    assign wr_rl_hi = do_write && (wr_sel == SEL_RELOAD) && w_strb[1];
    assign wr_clr = do_write && (wr_sel == SEL_IRQ_CLEAR) && w_strb[0];

    // Read channel
    assign rd_sel = decode_reg(s_axi_araddr);

    always_comb begin
        rd_word = '0;
        unique case (rd_sel)
            SEL_CONTROL: rd_word[7:0] = ctrl;
            SEL_COUNT: rd_word[15:0] = {count_high_byte, count_low_byte};
            SEL_RELOAD: rd_word[15:0] = {reload_high_byte, reload_low_byte};
            SEL_CLOCK_CONTROL: rd_word[1:0] = clock_control;
            SEL_IRQ_STATUS: rd_word[2:0] = irq_status;
            SEL_IRQ_ENABLE: rd_word[2:0] = irq_enable;
            SEL_IRQ_CLEAR, SEL_NONE: rd_word = '0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'h1;
            s_axi_rvalid <= 1'h0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arready <= 1'h0;
                s_axi_rvalid <= 1'h1;
                s_axi_rdata <= rd_word;
                s_axi_rresp <= (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
            end
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'h0;
                s_axi_arready <= 1'h1;
            end
        end
    end

    // Count enables per byte
    assign lo_tick = pick_tick(clock_control[CLKSEL_LOW], ctrl.external_clock_select,
                               ticks);
    assign hi_tick = pick_tick(clock_control[CLKSEL_HIGH], ctrl.external_clock_select,
                               ticks);
    assign capture = ctrl.lfo_capture_enable && ticks.lfo_fall;

    // Counter next state
    always_comb begin
        next_lo = count_low_byte;
        next_hi = count_high_byte;
        lo_ovf = 1'h0;
        hi_ovf = 1'h0;
        if (ctrl.split_mode_enable) begin
            if (lo_tick) begin
                if (count_low_byte == BYTE_ALL_ONES) begin
                    next_lo = reload_low_byte;
                    lo_ovf = 1'h1;
                end else begin
                    next_lo = count_low_byte + 8'h01;
                end
            end
            if (ctrl.run_control && hi_tick) begin
                if (count_high_byte == BYTE_ALL_ONES) begin
                    next_hi = reload_high_byte;
                    hi_ovf = 1'h1;
                end else begin
                    next_hi = count_high_byte + 8'h01;
                end
            end
        end else if (ctrl.run_control && lo_tick) begin
            lo_ovf = (count_low_byte == BYTE_ALL_ONES);
            if ({count_high_byte, count_low_byte} == {BYTE_ALL_ONES, BYTE_ALL_ONES}) begin
                {next_hi, next_lo} = {reload_high_byte, reload_low_byte};
                hi_ovf = 1'h1;
            end else begin
                {next_hi, next_lo} = 16'({count_high_byte, count_low_byte} + 16'h0001);
            end
        end
        if (wr_cnt_lo) begin
            next_lo = w_data[7:0];
        end
        if (wr_cnt_hi) begin
            next_hi = w_data[15:8];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_low_byte <= BYTE_RESET;
            count_high_byte <= BYTE_RESET;
        end else begin
            count_low_byte <= next_lo;
            count_high_byte <= next_hi;
        end
    end

    // Reload registers, capture wins over software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            reload_low_byte <= BYTE_RESET;
            reload_high_byte <= BYTE_RESET;
        end else if (capture) begin
            reload_low_byte <= count_low_byte;
            reload_high_byte <= count_high_byte;
        end else begin
            if (wr_rl_lo) begin
                reload_low_byte <= w_data[7:0];
            end
            if (wr_rl_hi) begin
                reload_high_byte <= w_data[15:8];
            end
        end
    end

    // Control register, hardware set wins over software clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl <= CONTROL_RESET;
        end else begin
            if (wr_ctrl) begin
                ctrl.low_byte_irq_enable <= w_data[5];
                ctrl.lfo_capture_enable <= w_data[4];
                ctrl.split_mode_enable <= w_data[3];
                ctrl.run_control <= w_data[2];
                ctrl.external_clock_select <= w_data[0];
            end
            ctrl.unused <= 1'h0;
            if (hi_ovf) begin
                ctrl.high_byte_overflow_flag <= 1'h1;
            end else if (wr_ctrl) begin
                ctrl.high_byte_overflow_flag <= w_data[7];
            end else if (wr_clr && w_data[IRQ_HIGH]) begin
                ctrl.high_byte_overflow_flag <= 1'h0;
            end
            if (lo_ovf) begin
                ctrl.low_byte_overflow_flag <= 1'h1;
            end else if (wr_ctrl) begin
                ctrl.low_byte_overflow_flag <= w_data[6];
            end else if (wr_clr && w_data[IRQ_LOW]) begin
                ctrl.low_byte_overflow_flag <= 1'h0;
            end
        end
    end

    // Clock control and interrupt enables
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_control <= 2'h0;
            irq_enable <= IRQ_RESET;
        end else begin
            if (do_write && (wr_sel == SEL_CLOCK_CONTROL) && w_strb[0]) begin
                clock_control <= w_data[1:0];
            end
            if (do_write && (wr_sel == SEL_IRQ_ENABLE) && w_strb[0]) begin
                irq_enable <= w_data[2:0];
            end
        end
    end

    // Capture event status
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_flag <= 1'h0;
        end else if (capture) begin
            capture_flag <= 1'h1;
        end else if (wr_clr && w_data[IRQ_CAPTURE]) begin
            capture_flag <= 1'h0;
        end
    end

    assign irq_status = {capture_flag, ctrl.low_byte_overflow_flag, ctrl.high_byte_overflow_flag};

    // Interrupt request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq <= 1'h0;
        end else begin
            irq <= irq_enable[IRQ_HIGH] && (irq_status[IRQ_HIGH]
                   || (irq_status[IRQ_LOW] && irq_enable[IRQ_LOW]
                       && ctrl.low_byte_irq_enable)
                   || (irq_status[IRQ_CAPTURE] && irq_enable[IRQ_CAPTURE]));
        end
    end

    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    AST_LOW_FREE_RUN: assert property (
        ctrl.split_mode_enable && !ctrl.run_control && lo_tick && !wr_cnt_lo
        && count_low_byte != BYTE_ALL_ONES |=> count_low_byte == 8'($past(count_low_byte) + 1))
        else $error("low byte did not count while stopped");
    AST_HIGH_GATED: assert property (
        ctrl.split_mode_enable && !ctrl.run_control && !wr_cnt_hi |=> $stable(count_high_byte))
        else $error("high byte moved while stopped");
    AST_LOW_RELOAD: assert property (
        ctrl.split_mode_enable && lo_tick && !wr_cnt_lo && count_low_byte == BYTE_ALL_ONES
        |=> count_low_byte == $past(reload_low_byte) && ctrl.low_byte_overflow_flag)
        else $error("low byte reload or flag missing");
    AST_HIGH_RELOAD: assert property (
        ctrl.split_mode_enable && ctrl.run_control && hi_tick && !wr_cnt_hi
        && count_high_byte == BYTE_ALL_ONES
        |=> count_high_byte == $past(reload_high_byte) && ctrl.high_byte_overflow_flag)
        else $error("high byte reload or flag missing");
    AST_FULL_WRAP: assert property (
        !ctrl.split_mode_enable && ctrl.run_control && lo_tick && !wr_cnt_lo && !wr_cnt_hi
        && {count_high_byte, count_low_byte} == 16'hFFFF |=> ctrl.high_byte_overflow_flag
        && ctrl.low_byte_overflow_flag && count_high_byte == $past(reload_high_byte))
        else $error("16-bit rollover mishandled");
    AST_STOPPED_16: assert property (
        !ctrl.split_mode_enable && !ctrl.run_control && !wr_cnt_lo && !wr_cnt_hi
        |=> $stable({count_high_byte, count_low_byte}))
        else $error("16-bit counter moved while stopped");
    AST_FLAG_STICKY: assert property (
        ctrl.high_byte_overflow_flag && !wr_ctrl && !wr_clr |=> ctrl.high_byte_overflow_flag)
        else $error("high flag cleared by hardware");
    AST_CAPTURE: assert property (
        capture |=> {reload_high_byte, reload_low_byte}
                    == $past({count_high_byte, count_low_byte}))
        else $error("capture did not copy count");
    AST_IRQ_HIGH: assert property (
        ctrl.high_byte_overflow_flag && irq_enable[IRQ_HIGH] |=> irq)
        else $error("interrupt missing for high flag");
    AST_UNUSED_BIT: assert property (
        s_axi_rvalid && $rose(s_axi_rvalid) && $past(rd_sel) == SEL_CONTROL
        |-> !s_axi_rdata[1])
        else $error("unused control bit read nonzero");
    COV_LOW_WRAP: cover property (ctrl.split_mode_enable && lo_ovf);
    COV_FULL_WRAP: cover property (!ctrl.split_mode_enable && hi_ovf);
    COV_CAPTURE: cover property (capture ##2 irq);
    COV_LOW_IRQ: cover property (lo_ovf ##[1:4] irq);

endmodule : split_mode_auto_reload_timer
`default_nettype wire

// File: testbench/split_mode_auto_reload_timer_bench.sv
`default_nettype none
module split_mode_auto_reload_timer_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import timer2_pkg::*;

    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [7:0] s_axi_araddr = 8'h00;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic ext_clk_in = 1'b0;
    logic lfo_in = 1'b1;
    logic irq;
    int errors = 0;
    int checked = 0;
    int seed = 32'h1ae73927;
    logic [65:0] rq[$];
    logic [1:0] wq[$];
    logic [65:0] rnote;
    logic [15:0] cap_val;

    split_mode_auto_reload_timer dut (.aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .ext_clk_in(ext_clk_in),
        .lfo_in(lfo_in), .irq(irq));

    initial begin
        forever #2 aclk = ~aclk;
    end

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
        bit aw_done;
        bit w_done;
        aw_done = 0;
        w_done = 0;
        wq.push_back(r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready && !aw_done) begin
                aw_done = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_done) begin
                w_done = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid === 1'b1) break;
        end
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = 32'hFFFFFFFF,
                      input logic [1:0] r = RESP_OKAY);
        bit ar_done;
        ar_done = 0;
        rq.push_back({r, m, e});
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready && !ar_done) begin
                ar_done = 1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid === 1'b1) break;
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    task automatic ext_pulses(input int n);
        int h;
        repeat (n) begin
            h = 2 + ({$random(seed)} % 4);
            repeat (h) @(posedge aclk);
            ext_clk_in <= 1'b1;
            repeat (h) @(posedge aclk);
            ext_clk_in <= 1'b0;
        end
    endtask : ext_pulses

    task automatic irq_is(input logic e);
        repeat (4) @(posedge aclk);
        chk("irq", {31'h0, e}, {31'h0, irq});
    endtask : irq_is

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : wrap_up

    // Response monitor: each answer is matched against the oldest note
    always @(posedge aclk) begin
        if (s_axi_rvalid === 1'b1 && s_axi_rready) begin
            rnote = rq.pop_front();
            chk("rdata", rnote[31:0] & rnote[63:32], s_axi_rdata & rnote[63:32]);
            chk("rresp", {30'h0, rnote[65:64]}, {30'h0, s_axi_rresp});
        end
        if (s_axi_bvalid === 1'b1 && s_axi_bready) begin
            chk("bresp", {30'h0, wq.pop_front()}, {30'h0, s_axi_bresp});
        end
    end

    initial begin
        repeat (20000) @(posedge aclk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(ADDR_CONTROL, 32'h0);
        rd(ADDR_COUNT, 32'h0);
        rd(ADDR_RELOAD, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h0);
        rd(ADDR_CLOCK_CONTROL, 32'h0);
        rd(8'hF0, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
        wr(8'hF0, 32'h1, RESP_SLVERR);
        wr(ADDR_CONTROL, 32'h32);
        rd(ADDR_CONTROL, 32'h30);
        // Split mode, low byte on system clock, high byte stopped
        wr(ADDR_RELOAD, 32'hA0A0);
        wr(ADDR_COUNT, 32'h55FE);
        wr(ADDR_CLOCK_CONTROL, 32'h3);
        wr(ADDR_CONTROL, 32'h08);
        repeat (300) @(posedge aclk);
        rd(ADDR_COUNT, 32'h5580, 32'hFF80);
        rd(ADDR_IRQ_STATUS, 32'h2, 32'h3);
        wr(ADDR_CONTROL, 32'h0C);
        repeat (300) @(posedge aclk);
        rd(ADDR_COUNT, 32'h8080, 32'h8080);
        rd(ADDR_IRQ_STATUS, 32'h3, 32'h3);
        wr(ADDR_IRQ_ENABLE, 32'h1);
        irq_is(1'b1);
        // External source selected but idle: both bytes freeze
        wr(ADDR_CONTROL, 32'hCD);
        wr(ADDR_CLOCK_CONTROL, 32'h0);
        repeat (100) @(posedge aclk);
        rd(ADDR_IRQ_STATUS, 32'h3, 32'h3);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        rd(ADDR_IRQ_STATUS, 32'h0, 32'h7);
        rd(ADDR_CONTROL, 32'h0D);
        irq_is(1'b0);
        wr(ADDR_COUNT, 32'h55FE);
        wr(ADDR_IRQ_ENABLE, 32'h3);
        ext_pulses(16);
        repeat (10) @(posedge aclk);
        rd(ADDR_COUNT, 32'h57A0);
        rd(ADDR_IRQ_STATUS, 32'h2, 32'h7);
        irq_is(1'b0);
        wr(ADDR_CONTROL, 32'h69);
        irq_is(1'b1);
        // Full 16-bit counter
        wr(ADDR_CONTROL, 32'h00);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        wr(ADDR_RELOAD, 32'h1234);
        wr(ADDR_COUNT, 32'hFFFE);
        wr(ADDR_CLOCK_CONTROL, 32'h0);
        wr(ADDR_CONTROL, 32'h04);
        repeat (40) @(posedge aclk);
        rd(ADDR_IRQ_STATUS, 32'h3, 32'h3);
        rd(ADDR_COUNT, 32'h1230, 32'hFFF0);
        wr(ADDR_CONTROL, 32'h00);
        wr(ADDR_IRQ_CLEAR, 32'h7);
        // Oscillator capture of a random frozen count
        cap_val = 16'($random(seed));
        wr(ADDR_COUNT, {16'h0, cap_val});
        wr(ADDR_IRQ_ENABLE, 32'h5);
        wr(ADDR_CONTROL, 32'h10);
        lfo_in <= 1'b0;
        repeat (10) @(posedge aclk);
        rd(ADDR_RELOAD, {16'h0, cap_val});
        rd(ADDR_IRQ_STATUS, 32'h4, 32'h7);
        irq_is(1'b1);
        wrap_up();
    end
endmodule : split_mode_auto_reload_timer_bench
`default_nettype wire
